/* fovr_pkg.sv */
// Constants and types for the eight-channel forced override and blink warning block.
// Assumes a single 40 MHz clock and an AXI4-Lite register bus with 32-bit data.
package fovr_pkg;
	// Clock rate and the millisecond time base of the warning timers
	localparam int unsigned CLK_HZ = 40_000_000;
	localparam int unsigned TICK_NS = 1_000_000;
	localparam int unsigned TICK_CYC = TICK_NS / (1_000_000_000 / CLK_HZ);
	localparam int NCH = 8;
	localparam int AW = 8;
	// Register byte offsets
	localparam logic [7:0] OFS_BLINK_EN = 8'h00;
	localparam logic [7:0] OFS_RELAY_NC = 8'h04;
	localparam logic [7:0] OFS_WARN_CFG = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	// Reset values: 3 blinks, 100 ms apart, 1000 ms before off
	localparam logic [7:0] RST_BLINK_EN = 8'h00;
	localparam logic [7:0] RST_RELAY_NC = 8'h00;
	localparam logic [31:0] RST_WARN_CFG = 32'h03E8_6403;
	localparam logic [31:0] CFG_WMASK = 32'hFFFF_FF0F;
	// Status field positions
	localparam int STS_CONTACT_LSB = 0;
	localparam int STS_FORCE_LSB = 8;
	localparam int STS_WARN_LSB = 16;
	// Bus responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Forced-control value as received: activation bit above forced level
	typedef struct packed {
		logic act;
		logic lvl;
	} fovr_frc_t;

	// Shared warning timing: delay [31:16], interval [15:8], blink count [3:0]
	typedef struct packed {
		logic [15:0] delay;
		logic [7:0] interval;
		logic [3:0] rsv;
		logic [3:0] count;
	} fovr_cfg_t;

	// Per-channel warning sequence, coded IDLE 0, WARN 1, HOLD 3
	typedef enum logic [1:0] {
		FOVR_IDLE = 2'h0,
		FOVR_WARN = 2'h1,
		FOVR_HOLD = 2'h3
	} fovr_st_t;
endpackage

/* fovr_top.sv */
// Eight-channel forced override with blink warning and relay contact mode.
// Assumes switching and forced-control updates arrive as one-cycle strobes from a
// telegram decoder on clk_in, and software reaches the settings over AXI4-Lite.
//
// Decided for this implementation: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps

module fovr_top #(
	parameter int unsigned TICK_CYC = fovr_pkg::TICK_CYC
) (
	input wire logic clk_in,
	input wire logic resetn_in,
	input wire logic [7:0] sw_val_in,
	input wire logic [7:0] sw_stb_in,
	input wire fovr_pkg::fovr_frc_t [7:0] frc_in,
	input wire logic [7:0] frc_stb_in,
	output logic [7:0] contact_out,
	input wire logic [7:0] s_awaddr_in,
	input wire logic s_awvalid_in,
	output logic s_awready_out,
	input wire logic [31:0] s_wdata_in,
	input wire logic [3:0] s_wstrb_in,
	input wire logic s_wvalid_in,
	output logic s_wready_out,
	output logic [1:0] s_bresp_out,
	output logic s_bvalid_out,
	input wire logic s_bready_in,
	input wire logic [7:0] s_araddr_in,
	input wire logic s_arvalid_in,
	output logic s_arready_out,
	output logic [31:0] s_rdata_out,
	output logic [1:0] s_rresp_out,
	output logic s_rvalid_out,
	input wire logic s_rready_in
);
	// All checks run on the one clock and rest while reset is low
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (!resetn_in);

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++)
		begin
			if (strb[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		end
		return r;
	endfunction

	logic [7:0] blink_en_q, blink_en_d, relay_nc_q, relay_nc_d;
	fovr_pkg::fovr_cfg_t cfg_q, cfg_d;
	logic aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	logic [15:0] div_q, div_d;
	logic tick;
	logic [7:0] sw_q, sw_d, lvl_q, lvl_d, contact_q, contact_d;
	fovr_pkg::fovr_frc_t [7:0] frc_q, frc_d;
	fovr_pkg::fovr_st_t st_q [8];
	fovr_pkg::fovr_st_t st_d [8];
	logic [4:0] cnt_q [8];
	logic [4:0] cnt_d [8];
	logic [15:0] tmr_q [8];
	logic [15:0] tmr_d [8];
	logic [7:0] stage, warn;

	assign s_awready_out = !aw_got_q && !bvalid_q;
	assign s_wready_out = !w_got_q && !bvalid_q;
	assign s_bvalid_out = bvalid_q;
	assign s_bresp_out = bresp_q;
	assign s_arready_out = !rvalid_q;
	assign s_rvalid_out = rvalid_q;
	assign s_rdata_out = rdata_q;
	assign s_rresp_out = rresp_q;
	assign contact_out = contact_q;

	// Write channel: capture address and data in either order, then commit
	always_comb
	begin
		aw_got_d = aw_got_q;
		w_got_d = w_got_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		blink_en_d = blink_en_q;
		relay_nc_d = relay_nc_q;
		cfg_d = cfg_q;
		if (s_awvalid_in && s_awready_out)
		begin
			aw_got_d = 1'b1;
			awaddr_d = s_awaddr_in;
		end
		if (s_wvalid_in && s_wready_out)
		begin
			w_got_d = 1'b1;
			wdata_d = s_wdata_in;
			wstrb_d = s_wstrb_in;
		end
		if (aw_got_q && w_got_q)
		begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = fovr_pkg::RESP_OKAY;
			case (awaddr_q)
				fovr_pkg::OFS_BLINK_EN: blink_en_d = 8'(merge({24'h0, blink_en_q}, wdata_q,
					wstrb_q));
				fovr_pkg::OFS_RELAY_NC: relay_nc_d = 8'(merge({24'h0, relay_nc_q}, wdata_q,
					wstrb_q));
				fovr_pkg::OFS_WARN_CFG: cfg_d = merge(cfg_q, wdata_q, wstrb_q) &
					fovr_pkg::CFG_WMASK;
				fovr_pkg::OFS_STATUS: bresp_d = fovr_pkg::RESP_OKAY;
				default: bresp_d = fovr_pkg::RESP_SLVERR;
			endcase
		end
		else if (bvalid_q && s_bready_in)
			bvalid_d = 1'b0;
	end

	// Write channel and settings registers
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			bvalid_q <= 1'b0;
			bresp_q <= 2'h0;
			blink_en_q <= fovr_pkg::RST_BLINK_EN;
			relay_nc_q <= fovr_pkg::RST_RELAY_NC;
			cfg_q <= fovr_pkg::RST_WARN_CFG;
		end
		else
		begin
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			blink_en_q <= blink_en_d;
			relay_nc_q <= relay_nc_d;
			cfg_q <= cfg_d;
		end
	end

	// Read channel: answer one cycle after the address is taken
	always_comb
	begin
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		if (s_arvalid_in && s_arready_out)
		begin
			rvalid_d = 1'b1;
			rresp_d = fovr_pkg::RESP_OKAY;
			rdata_d = 32'h0000_0000;
			case (s_araddr_in)
				fovr_pkg::OFS_BLINK_EN: rdata_d[7:0] = blink_en_q;
				fovr_pkg::OFS_RELAY_NC: rdata_d[7:0] = relay_nc_q;
				fovr_pkg::OFS_WARN_CFG: rdata_d = cfg_q;
				fovr_pkg::OFS_STATUS:
				begin
					rdata_d[fovr_pkg::STS_CONTACT_LSB +: 8] = contact_q;
					for (int i = 0; i < fovr_pkg::NCH; i++)
						rdata_d[fovr_pkg::STS_FORCE_LSB + i] = frc_q[i].act;
					rdata_d[fovr_pkg::STS_WARN_LSB +: 8] = warn;
				end
				default: rresp_d = fovr_pkg::RESP_SLVERR;
			endcase
		end
		else if (rvalid_q && s_rready_in)
			rvalid_d = 1'b0;
	end

	// Read channel registers
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= 2'h0;
		end
		else
		begin
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// Millisecond enable pulse for the warning timers
	always_comb
	begin
		tick = (div_q == 16'(TICK_CYC - 1));
		div_d = tick ? 16'h0000 : div_q + 16'h0001;
	end

	// Override stage and warning sequence per channel
	always_comb
	begin
		sw_d = sw_q;
		frc_d = frc_q;
		for (int i = 0; i < fovr_pkg::NCH; i++)
		begin
			if (sw_stb_in[i])
				sw_d[i] = sw_val_in[i];
			if (frc_stb_in[i])
				frc_d[i] = frc_in[i];
			stage[i] = frc_q[i].act ? frc_q[i].lvl : sw_q[i];
			warn[i] = (st_q[i] != fovr_pkg::FOVR_IDLE);
			st_d[i] = st_q[i];
			cnt_d[i] = cnt_q[i];
			tmr_d[i] = tmr_q[i];
			lvl_d[i] = lvl_q[i];
			if (stage[i] || frc_q[i].act)
			begin
				// Turning on or forcing cuts any warning short
				st_d[i] = fovr_pkg::FOVR_IDLE;
				lvl_d[i] = stage[i];
			end
			else
			begin
				case (st_q[i])
					fovr_pkg::FOVR_IDLE:
					begin
						lvl_d[i] = 1'b0;
						// start warning on a normal switch-off
						if (lvl_q[i] && blink_en_q[i])
						begin
							if (cfg_q.count == 4'h0)
							begin
								st_d[i] = fovr_pkg::FOVR_HOLD;
								lvl_d[i] = 1'b1;
								tmr_d[i] = cfg_q.delay;
							end
							else
							begin
								st_d[i] = fovr_pkg::FOVR_WARN;
								cnt_d[i] = {cfg_q.count, 1'b0} - 5'h01;
								tmr_d[i] = {8'h00, cfg_q.interval};
							end
						end
					end
					fovr_pkg::FOVR_WARN:
					begin
						if (tick && tmr_q[i] <= 16'h0001)
						begin
							tmr_d[i] = {8'h00, cfg_q.interval};
							lvl_d[i] = !lvl_q[i];
							if (cnt_q[i] == 5'h00)
							begin
								st_d[i] = fovr_pkg::FOVR_HOLD;
								lvl_d[i] = 1'b1;
								tmr_d[i] = cfg_q.delay;
							end
							else
								cnt_d[i] = cnt_q[i] - 5'h01;
						end
						else if (tick)
							tmr_d[i] = tmr_q[i] - 16'h0001;
					end
					fovr_pkg::FOVR_HOLD:
					begin
						if (tick && tmr_q[i] <= 16'h0001)
						begin
							st_d[i] = fovr_pkg::FOVR_IDLE;
							lvl_d[i] = 1'b0;
						end
						else if (tick)
							tmr_d[i] = tmr_q[i] - 16'h0001;
					end
					default:
					begin
						st_d[i] = fovr_pkg::FOVR_IDLE;
						lvl_d[i] = 1'b0;
					end
				endcase
			end
		end
		// normally open passes the level, closed inverts it
		contact_d = lvl_q ^ relay_nc_q;
	end

	// Channel state registers
	always_ff @(posedge clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			div_q <= 16'h0000;
			sw_q <= 8'h00;
			frc_q <= '0;
			lvl_q <= 8'h00;
			contact_q <= 8'h00;
			for (int i = 0; i < fovr_pkg::NCH; i++)
			begin
				st_q[i] <= fovr_pkg::FOVR_IDLE;
				cnt_q[i] <= 5'h00;
				tmr_q[i] <= 16'h0000;
			end
		end
		else
		begin
			div_q <= div_d;
			sw_q <= sw_d;
			frc_q <= frc_d;
			lvl_q <= lvl_d;
			contact_q <= contact_d;
			for (int i = 0; i < fovr_pkg::NCH; i++)
			begin
				st_q[i] <= st_d[i];
				cnt_q[i] <= cnt_d[i];
				tmr_q[i] <= tmr_d[i];
			end
		end
	end

	// Checks on every channel
	for (genvar g = 0; g < 8; g++)
	begin : g_chk
		a_force_on_lvl: assert property (frc_stb_in[g] && frc_in[g] == 2'h3
			|=> ##1 lvl_q[g])
			else $error("forced on did not drive level high");
		a_force_off_lvl: assert property (frc_stb_in[g] && frc_in[g] == 2'h2
			|=> ##1 !lvl_q[g])
			else $error("forced off did not drive level low");
		a_frc_capture: assert property (frc_stb_in[g] |=> frc_q[g] == $past(frc_in[g]))
			else $error("forced value not captured");
		a_sw_ignored: assert property (frc_q[g].act |=> lvl_q[g] == $past(frc_q[g].lvl))
			else $error("switching input leaked through active override");
		a_act_bit_used: assert property (frc_q[g] == 2'h1 && !sw_q[g] |-> !stage[g])
			else $error("low bit acted while override passive");
		a_pass_on: assert property (!frc_q[g].act && sw_q[g] |=> lvl_q[g])
			else $error("passive override did not pass switching on");
		a_resume_sw: assert property ($fell(frc_q[g].act) && !blink_en_q[g]
			|=> lvl_q[g] == $past(sw_q[g]))
			else $error("output did not follow last switching value");
		a_no_contact: assert property (!relay_nc_q[g] |=> contact_q[g] == $past(lvl_q[g]))
			else $error("normally open contact does not follow level");
		a_warn_gate: assert property (st_q[g] == fovr_pkg::FOVR_IDLE && !blink_en_q[g]
			|=> st_q[g] == fovr_pkg::FOVR_IDLE)
			else $error("warning started on a disabled channel");
		a_warn_load: assert property (st_q[g] == fovr_pkg::FOVR_WARN
			&& $past(st_q[g]) == fovr_pkg::FOVR_IDLE
			|-> cnt_q[g] == {$past(cfg_q.count), 1'b0} - 5'h01)
			else $error("warning count not loaded from shared setting");
		c_force_on: cover property (frc_stb_in[g] && frc_in[g] == 2'h3);
		c_force_off: cover property (frc_stb_in[g] && frc_in[g] == 2'h2);
		c_warn_start: cover property (st_q[g] == fovr_pkg::FOVR_WARN);
		c_hold_done: cover property (st_q[g] == fovr_pkg::FOVR_HOLD ##1 st_q[g] == fovr_pkg::FOVR_IDLE);
	end
endmodule

/* fovr_tlg_src.sv */
// Model of the automation bus side: a telegram decoder issuing channel updates.
// Assumes the block samples values on clk_in while the matching strobe bit is high.
`timescale 1ns/1ps
module fovr_tlg_src (
	input wire logic clk_in,
	output logic [7:0] sw_val_out,
	output logic [7:0] sw_stb_out,
	output fovr_pkg::fovr_frc_t [7:0] frc_out,
	output logic [7:0] frc_stb_out
);
	// Idle lines start low
	initial
	begin
		sw_val_out = 8'h00;
		sw_stb_out = 8'h00;
		frc_out = 16'h0000;
		frc_stb_out = 8'h00;
	end

	task automatic send(input logic [7:0] sws, sw, frs, input logic [15:0] frc);
		@(posedge clk_in);
		sw_stb_out <= sws;
		sw_val_out <= sw;
		frc_stb_out <= frs;
		frc_out <= frc;
		@(posedge clk_in);
		sw_stb_out <= 8'h00;
		frc_stb_out <= 8'h00;
		sw_val_out <= ~sw; // Stale data inverted once released
		frc_out <= ~frc;
	endtask
endmodule

/* test_forced_override_blink_warn.sv */
// Self-checking bench for the forced override block with its register bus.
// Assumes fovr_tlg_src drives the channel inputs; the bench is the bus master.
`timescale 1ns/1ps
module test_forced_override_blink_warn;
	typedef struct packed {
		logic [7:0] sws;
		logic [7:0] sw;
		logic [7:0] frs;
		logic [15:0] frc;
		logic [7:0] exp;
	} fovr_row_t;
	logic clk_in, resetn_in, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] sw_val, sw_stb, frc_stb, contact, awaddr, araddr;
	fovr_pkg::fovr_frc_t [7:0] frc;
	logic [31:0] wdata, rdata, rd;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, rs;
	int error_cnt, check_count;
	fovr_row_t rows [7] = '{
		'{8'hFF, 8'hAA, 8'hFF, 16'h0000, 8'hAA}, '{8'h00, 8'h00, 8'hFF, 16'h5555, 8'hAA},
		'{8'hFF, 8'h55, 8'hFF, 16'hAAAA, 8'h00}, '{8'hFF, 8'h0F, 8'h00, 16'h0000, 8'h00},
		'{8'h00, 8'h00, 8'hFF, 16'hFFFF, 8'hFF}, '{8'hFF, 8'h3C, 8'hFF, 16'hAAFF, 8'h0F},
		'{8'h00, 8'h00, 8'hFF, 16'h0000, 8'h3C}};

	fovr_tlg_src fovr_tlg_src_inst (.clk_in(clk_in), .sw_val_out(sw_val), .sw_stb_out(sw_stb),
		.frc_out(frc), .frc_stb_out(frc_stb));
	fovr_top #(.TICK_CYC(4)) fovr_top_inst (.clk_in(clk_in), .resetn_in(resetn_in),
		.sw_val_in(sw_val), .sw_stb_in(sw_stb), .frc_in(frc), .frc_stb_in(frc_stb),
		.contact_out(contact), .s_awaddr_in(awaddr), .s_awvalid_in(awvalid),
		.s_awready_out(awready), .s_wdata_in(wdata), .s_wstrb_in(wstrb),
		.s_wvalid_in(wvalid), .s_wready_out(wready), .s_bresp_out(bresp),
		.s_bvalid_out(bvalid), .s_bready_in(bready), .s_araddr_in(araddr),
		.s_arvalid_in(arvalid), .s_arready_out(arready), .s_rdata_out(rdata),
		.s_rresp_out(rresp), .s_rvalid_out(rvalid), .s_rready_in(rready));

	// Clock, 25 ns period
	initial
	begin
		clk_in = 1'b0;
		forever #12.5 clk_in = ~clk_in;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic test_done;
		if (error_cnt == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Handshakes are judged at the falling edge, acted on at the next rising edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bit ha, hw, hb;
		@(posedge clk_in);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(negedge clk_in);
			ha = awvalid && awready;
			hw = wvalid && wready;
			hb = bvalid && bready;
			rs = bresp;
			@(posedge clk_in);
			if (ha) awvalid <= 1'b0;
			if (hw) wvalid <= 1'b0;
		end
		while (!hb);
		bready <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		bit ha, hr;
		@(posedge clk_in);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(negedge clk_in);
			ha = arvalid && arready;
			hr = rvalid && rready;
			rd = rdata;
			rs = rresp;
			@(posedge clk_in);
			if (ha) arvalid <= 1'b0;
		end
		while (!hr);
		rready <= 1'b0;
	endtask

	task automatic settle;
		repeat (3) @(posedge clk_in);
		@(negedge clk_in);
	endtask

	// Watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge clk_in);
		error_cnt++;
		test_done();
	end

	// Main sequence: reset, table rows, then bus and warning cases
	initial
	begin
		{resetn_in, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h0, 4'hF};
		repeat (4) @(posedge clk_in);
		resetn_in <= 1'b1;
		@(negedge clk_in);
		chk(contact, 32'h0);
		rd_reg(fovr_pkg::OFS_WARN_CFG);
		chk(rd, fovr_pkg::RST_WARN_CFG);
		foreach (rows[i])
		begin
			fovr_tlg_src_inst.send(rows[i].sws, rows[i].sw, rows[i].frs, rows[i].frc);
			settle();
			chk(contact, rows[i].exp);
		end
		// Unmapped place answers with an error
		wr(8'h10, 32'h1234_5678);
		chk(rs, fovr_pkg::RESP_SLVERR);
		rd_reg(8'h10);
		chk(rs, fovr_pkg::RESP_SLVERR);
		chk(rd, 32'h0);
		// Shared timing, warning enabled on channels 0 and 2 only
		wr(fovr_pkg::OFS_WARN_CFG, 32'h0002_01F1);
		rd_reg(fovr_pkg::OFS_WARN_CFG);
		chk(rd, 32'h0002_0101);
		wr(fovr_pkg::OFS_BLINK_EN, 32'h0000_0005);
		fovr_tlg_src_inst.send(8'hFF, 8'hFF, 8'h00, 16'h0000);
		fovr_tlg_src_inst.send(8'hFF, 8'h00, 8'h00, 16'h0000);
		rd_reg(fovr_pkg::OFS_STATUS);
		chk(rd[23:8], 16'h0500);
		repeat (80) @(posedge clk_in);
		rd_reg(fovr_pkg::OFS_STATUS);
		chk(rd, 32'h0);
		// Normally closed mode inverts the contact
		wr(fovr_pkg::OFS_RELAY_NC, 32'h0000_0001);
		settle();
		chk(contact, 32'h1);
		// Byte lane 0 masked: the enables keep their value
		wstrb <= 4'hE;
		wr(fovr_pkg::OFS_BLINK_EN, 32'h0000_00FF);
		wstrb <= 4'hF;
		rd_reg(fovr_pkg::OFS_BLINK_EN);
		chk(rd, 32'h5);
		// Reset in mid-run clears the contacts and returns the settings to their reset values
		@(posedge clk_in);
		resetn_in <= 1'b0;
		@(negedge clk_in);
		chk(contact, 32'h0);
		repeat (2) @(posedge clk_in);
		resetn_in <= 1'b1;
		rd_reg(fovr_pkg::OFS_RELAY_NC);
		chk(rd, 32'h0);
		rd_reg(fovr_pkg::OFS_WARN_CFG);
		chk(rd, fovr_pkg::RST_WARN_CFG);
		test_done();
	end
endmodule
